// *** src/lsm_pkg.sv ***
package lsm_pkg;

  // ---------------------------------------------------------------
  // clock and monitoring tick
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1_000_000;
  localparam int unsigned TICK_DEFAULT_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned RESP_W = 8;
  localparam int unsigned WEIGHT_W = 8;
  localparam int unsigned LEVELS = 4;

  typedef logic [1:0] level_t;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_VAR_WORD = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_DELAY = 8'h10;
  localparam logic [7:0] OFS_WEIGHT = 8'h14;
  localparam logic [7:0] OFS_BUS_FAIL = 8'h18;
  localparam logic [7:0] OFS_GEAR_A = 8'h1c;
  localparam logic [7:0] OFS_GEAR_B = 8'h20;
  localparam logic [7:0] OFS_GEAR_C = 8'h24;
  localparam logic [7:0] OFS_SP_POS = 8'h28;
  localparam logic [7:0] OFS_SP_NEG = 8'h2c;
  localparam logic [7:0] OFS_LIMIT_0 = 8'h30;
  localparam logic [7:0] OFS_RESP_0 = 8'h40;
  localparam int unsigned TABLE_STRIDE = 4;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_SEL_BIT = 0;
  localparam int unsigned CTRL_LVL_LSB = 1;
  localparam int unsigned CFG_VAR_EN_BIT = 0;
  localparam int unsigned CFG_LINEAR_BIT = 1;
  localparam int unsigned ST_ACTIVE_BIT = 0;
  localparam int unsigned ST_LVL_LSB = 1;
  localparam int unsigned ST_SEL_LSB = 3;
  localparam int unsigned ST_FAULT_BIT = 5;
  localparam int unsigned ST_ALARM_BIT = 6;
  localparam int unsigned ST_ESR_BIT = 7;
  localparam int unsigned ST_PEND_BIT = 8;

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [15:0] VAR_FULL_SCALE = 16'h7fff;
  localparam logic [7:0] ESR_RESP_MIN = 8'h0a;
  localparam logic [7:0] PERCENT_FULL = 8'h64;
  localparam logic [31:0] DELAY_RST = 32'h0000_0064;
  localparam logic [7:0] WEIGHT_RST = 8'h64;
  localparam logic [15:0] GEAR_RST = 16'h0001;
  localparam logic [15:0] LIMIT_RST = 16'hffff;

endpackage : lsm_pkg

// *** src/monitor_if.sv ***
`timescale 1ns/1ps
interface monitor_if;
  // delay timer
  logic tmr_start;
  logic [31:0] tmr_delay;
  logic tmr_done;
  logic tmr_busy;
  // limit scaling
  logic [15:0] sc_limit1;
  logic [15:0] sc_word;
  logic [15:0] sc_limit;
  logic [7:0] sc_weight;
  logic [15:0] sc_gear_a;
  logic [15:0] sc_gear_b;
  logic [15:0] sc_gear_c;
  logic sc_linear;
  logic [15:0] sc_var_limit;
  logic [31:0] sc_sp_pos;
  logic [31:0] sc_sp_neg;

  modport core (
    output tmr_start, tmr_delay, sc_limit1, sc_word, sc_limit, sc_weight,
    output sc_gear_a, sc_gear_b, sc_gear_c, sc_linear,
    input tmr_done, tmr_busy, sc_var_limit, sc_sp_pos, sc_sp_neg
  );
  modport timer (
    input tmr_start, tmr_delay,
    output tmr_done, tmr_busy
  );
  modport scaler (
    input sc_limit1, sc_word, sc_limit, sc_weight, sc_gear_a, sc_gear_b,
    input sc_gear_c, sc_linear,
    output sc_var_limit, sc_sp_pos, sc_sp_neg
  );
endinterface : monitor_if

// *** src/limit_delay_timer.sv ***
`timescale 1ns/1ps
module limit_delay_timer #(
  parameter int unsigned TICK_CYCLES = lsm_pkg::TICK_DEFAULT_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // core side
  monitor_if.timer mif
);

  typedef struct packed {
    logic [31:0] div;
    logic [31:0] remain;
    logic busy;
    logic done;
  } tmr_state_t;

  tmr_state_t st_reg;
  tmr_state_t st_next;
  logic tick;

  assign mif.tmr_done = st_reg.done;
  assign mif.tmr_busy = st_reg.busy;
  assign tick = (st_reg.div == 32'(TICK_CYCLES - 1));

  // ---------------------------------------------------------------
  // countdown in monitoring ticks
  // ---------------------------------------------------------------
  // a start while busy restarts from the full delay
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (mif.tmr_start) begin
      st_next.busy = 1'b1;
      st_next.remain = mif.tmr_delay;
      st_next.div = '0;
    end else if (st_reg.busy) begin
      st_next.div = tick ? '0 : st_reg.div + 32'h0000_0001;
      if (tick) begin
        if (st_reg.remain <= 32'h0000_0001) begin
          st_next.busy = 1'b0;
          st_next.done = 1'b1;
        end else begin
          st_next.remain = st_reg.remain - 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_done_after_busy: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    st_reg.done |-> $past(st_reg.busy) && !$past(mif.tmr_start))
    else $error("delay expiry without a running delay");

endmodule : limit_delay_timer

// *** src/limit_scaler.sv ***
`timescale 1ns/1ps
module limit_scaler (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // core side
  monitor_if.scaler mif
);

  typedef struct packed {
    logic [15:0] var_limit;
    logic [31:0] sp_pos;
    logic [31:0] sp_neg;
  } sc_state_t;

  sc_state_t st_reg;
  sc_state_t st_next;

  assign mif.sc_var_limit = st_reg.var_limit;
  assign mif.sc_sp_pos = st_reg.sp_pos;
  assign mif.sc_sp_neg = st_reg.sp_neg;

  // ---------------------------------------------------------------
  // variable limit and setpoint limit pair
  // ---------------------------------------------------------------
  // wide intermediates; a zero gear divisor yields a zero limit, not X
  always_comb begin
    logic [31:0] prod;
    logic [63:0] weighted;
    logic [63:0] motor;
    prod = '0;
    weighted = '0;
    motor = '0;
    st_next = st_reg;
    prod = 32'(mif.sc_word) * 32'(mif.sc_limit1);
    st_next.var_limit = 16'(prod / 32'(lsm_pkg::VAR_FULL_SCALE));
    weighted = 64'(mif.sc_limit) * 64'(mif.sc_weight) / 64'(lsm_pkg::PERCENT_FULL);
    if (mif.sc_gear_c == '0) begin
      motor = '0;
    end else if (mif.sc_linear) begin
      motor = weighted * 64'(mif.sc_gear_b) * 64'(mif.sc_gear_a) / 64'(mif.sc_gear_c);
    end else begin
      motor = weighted * 64'(mif.sc_gear_b) / 64'(mif.sc_gear_c);
    end
    st_next.sp_pos = motor[31:0];
    st_next.sp_neg = 32'(-motor[31:0]);
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_pair_negated: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ##1 (st_reg.sp_pos + st_reg.sp_neg) == 32'h0000_0000)
    else $error("setpoint limit pair not symmetric");

endmodule : limit_scaler

// *** src/limited_speed_monitor.sv ***
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module limited_speed_monitor #(
  parameter int unsigned TICK_CYCLES = lsm_pkg::TICK_DEFAULT_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // process side
  input wire logic [15:0] speed_i,
  input wire logic comm_fail_i,
  // reactions
  output logic fault_o,
  output logic [7:0] fault_response_o,
  output logic alarm_o,
  output logic esr_o,
  output logic active_o,
  output logic [1:0] active_level_o
);

  typedef enum logic [1:0] {IDLE, DELAY_ON, MONITOR} mon_state_t;

  typedef struct packed {
    mon_state_t fsm;
    logic act;
    logic [31:0] ctrl;
    logic [15:0] var_word;
    logic [1:0] cfg;
    logic [31:0] delay;
    logic [7:0] weight;
    logic [31:0] bus_fail;
    logic [15:0] gear_a;
    logic [15:0] gear_b;
    logic [15:0] gear_c;
    logic [3:0][15:0] limits;
    logic [3:0][7:0] resp;
    lsm_pkg::level_t enf;
    lsm_pkg::level_t pend_lvl;
    logic pend;
    logic fault;
    logic [7:0] fault_resp;
    logic alarm;
    logic extended_stop_retract;
    logic [31:0] rdata;
  } mon_state_struct_t;

  mon_state_struct_t st_reg;
  mon_state_struct_t st_next;
  monitor_if mif ();

  logic sel;
  lsm_pkg::level_t req;
  logic var_en;
  logic var_use;
  logic inval;
  logic [15:0] lim_req;
  logic [15:0] lim_enf;
  logic active;
  logic [31:0] status;
  logic [7:0] tidx;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // level 1 uses the scaled word only when enabled; others use the table
  function automatic logic [15:0] lim_of(input lsm_pkg::level_t l, input logic en,
                                         input logic [15:0] vlim,
                                         input logic [3:0][15:0] tab);
    if (l == 2'b00 && en) begin
      return vlim;
    end
    return tab[l];
  endfunction : lim_of

  assign sel = st_reg.ctrl[lsm_pkg::CTRL_SEL_BIT];
  assign req = st_reg.ctrl[lsm_pkg::CTRL_LVL_LSB +: 2];
  assign var_en = st_reg.cfg[lsm_pkg::CFG_VAR_EN_BIT];
  assign var_use = sel && (req == 2'b00) && var_en;
  // zero or above full scale cannot be a legal word
  assign inval = var_use && (st_reg.var_word == '0 ||
                 st_reg.var_word > lsm_pkg::VAR_FULL_SCALE);
  assign lim_req = lim_of(req, var_en, mif.sc_var_limit, st_reg.limits);
  assign lim_enf = lim_of(st_reg.enf, var_en, mif.sc_var_limit, st_reg.limits);
  assign active = st_reg.act;
  assign tidx = addr_i - lsm_pkg::OFS_LIMIT_0;

  always_comb begin
    status = '0;
    status[lsm_pkg::ST_ACTIVE_BIT] = active;
    status[lsm_pkg::ST_LVL_LSB +: 2] = active ? st_reg.enf : 2'b00;
    status[lsm_pkg::ST_SEL_LSB +: 2] = req;
    status[lsm_pkg::ST_FAULT_BIT] = st_reg.fault;
    status[lsm_pkg::ST_ALARM_BIT] = st_reg.alarm;
    status[lsm_pkg::ST_ESR_BIT] = st_reg.extended_stop_retract;
    status[lsm_pkg::ST_PEND_BIT] = st_reg.pend;
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  assign mif.tmr_delay = st_reg.delay;
  assign mif.sc_limit1 = st_reg.limits[0];
  assign mif.sc_word = st_reg.var_word;
  assign mif.sc_limit = active ? lim_enf : 16'h0000;
  assign mif.sc_weight = st_reg.weight;
  assign mif.sc_gear_a = st_reg.gear_a;
  assign mif.sc_gear_b = st_reg.gear_b;
  assign mif.sc_gear_c = st_reg.gear_c;
  assign mif.sc_linear = st_reg.cfg[lsm_pkg::CFG_LINEAR_BIT];

  limit_delay_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .mif(mif.timer)
  );

  limit_scaler u_scaler (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .mif(mif.scaler)
  );

  // ---------------------------------------------------------------
  // registers, level sequencing, reactions
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    mif.tmr_start = 1'b0;
    st_next.rdata = '0;
    if (wr_i) begin
      case (addr_i)
        lsm_pkg::OFS_CTRL: st_next.ctrl = wdata_i;
        lsm_pkg::OFS_VAR_WORD: st_next.var_word = wdata_i[15:0];
        lsm_pkg::OFS_CONFIG: st_next.cfg = wdata_i[1:0];
        // changing the delay under way would break the timing promise
        lsm_pkg::OFS_DELAY: if (!sel) st_next.delay = wdata_i;
        lsm_pkg::OFS_WEIGHT: st_next.weight = wdata_i[7:0];
        lsm_pkg::OFS_BUS_FAIL: st_next.bus_fail = wdata_i;
        lsm_pkg::OFS_GEAR_A: st_next.gear_a = wdata_i[15:0];
        lsm_pkg::OFS_GEAR_B: st_next.gear_b = wdata_i[15:0];
        lsm_pkg::OFS_GEAR_C: st_next.gear_c = wdata_i[15:0];
        default: begin
          if (addr_i >= lsm_pkg::OFS_LIMIT_0 && addr_i < lsm_pkg::OFS_RESP_0) begin
            st_next.limits[tidx[3:2]] = wdata_i[15:0];
          end else if (addr_i >= lsm_pkg::OFS_RESP_0 &&
                       addr_i < 8'(lsm_pkg::OFS_RESP_0 + 8'h10)) begin
            st_next.resp[tidx[3:2]] = wdata_i[7:0];
          end
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        lsm_pkg::OFS_CTRL: st_next.rdata = st_reg.ctrl;
        lsm_pkg::OFS_STATUS: st_next.rdata = status;
        lsm_pkg::OFS_VAR_WORD: st_next.rdata = 32'(st_reg.var_word);
        lsm_pkg::OFS_CONFIG: st_next.rdata = 32'(st_reg.cfg);
        lsm_pkg::OFS_DELAY: st_next.rdata = st_reg.delay;
        lsm_pkg::OFS_WEIGHT: st_next.rdata = 32'(st_reg.weight);
        lsm_pkg::OFS_BUS_FAIL: st_next.rdata = st_reg.bus_fail;
        lsm_pkg::OFS_GEAR_A: st_next.rdata = 32'(st_reg.gear_a);
        lsm_pkg::OFS_GEAR_B: st_next.rdata = 32'(st_reg.gear_b);
        lsm_pkg::OFS_GEAR_C: st_next.rdata = 32'(st_reg.gear_c);
        lsm_pkg::OFS_SP_POS: st_next.rdata = mif.sc_sp_pos;
        lsm_pkg::OFS_SP_NEG: st_next.rdata = mif.sc_sp_neg;
        default: begin
          if (addr_i >= lsm_pkg::OFS_LIMIT_0 && addr_i < lsm_pkg::OFS_RESP_0) begin
            st_next.rdata = 32'(st_reg.limits[tidx[3:2]]);
          end else if (addr_i >= lsm_pkg::OFS_RESP_0 &&
                       addr_i < 8'(lsm_pkg::OFS_RESP_0 + 8'h10)) begin
            st_next.rdata = 32'(st_reg.resp[tidx[3:2]]);
          end
        end
      endcase
    end

    case (st_reg.fsm)
      IDLE: begin
        st_next.pend = 1'b0;
        if (sel) begin
          mif.tmr_start = 1'b1;
          st_next.pend_lvl = req;
          st_next.fsm = DELAY_ON;
        end
      end
      DELAY_ON: begin
        if (!sel) begin
          st_next.fsm = IDLE;
        end else if (req != st_reg.pend_lvl) begin
          mif.tmr_start = 1'b1;
          st_next.pend_lvl = req;
        end else if (mif.tmr_done) begin
          st_next.enf = st_reg.pend_lvl;
          st_next.fsm = MONITOR;
        end
      end
      MONITOR: begin
        if (!sel) begin
          st_next.fsm = IDLE;
          st_next.pend = 1'b0;
        end else if (st_reg.pend && mif.tmr_done) begin
          st_next.enf = st_reg.pend_lvl;
          st_next.pend = 1'b0;
        end else if (req != st_reg.enf) begin
          if (lim_req >= lim_enf) begin
            st_next.enf = req;
            st_next.pend = 1'b0;
          end else if (!st_reg.pend || st_reg.pend_lvl != req) begin
            mif.tmr_start = 1'b1;
            st_next.pend = 1'b1;
            st_next.pend_lvl = req;
          end
        end else begin
          st_next.pend = 1'b0;
        end
      end
      default: st_next.fsm = IDLE;
    endcase

    // reactions are levels recomputed each cycle; no flag to clear
    st_next.alarm = inval;
    if (inval) begin
      st_next.fault = 1'b1;
      st_next.fault_resp = st_reg.resp[0];
    end else if (active && sel && speed_i > lim_enf) begin
      st_next.fault = 1'b1;
      st_next.fault_resp = st_reg.resp[st_reg.enf];
    end else begin
      st_next.fault = 1'b0;
      st_next.fault_resp = '0;
    end
    st_next.extended_stop_retract = comm_fail_i && (st_reg.bus_fail != '0) && active && sel &&
                  (st_reg.resp[st_reg.enf] >= lsm_pkg::ESR_RESP_MIN);
    // registered twin of the state decode, so active_o leaves a flop
    st_next.act = (st_next.fsm == MONITOR);
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.fsm <= IDLE;
      st_reg.delay <= lsm_pkg::DELAY_RST;
      st_reg.weight <= lsm_pkg::WEIGHT_RST;
      st_reg.gear_a <= lsm_pkg::GEAR_RST;
      st_reg.gear_b <= lsm_pkg::GEAR_RST;
      st_reg.gear_c <= lsm_pkg::GEAR_RST;
      st_reg.limits <= {4{lsm_pkg::LIMIT_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign fault_o = st_reg.fault;
  assign fault_response_o = st_reg.fault_resp;
  assign alarm_o = st_reg.alarm;
  assign esr_o = st_reg.extended_stop_retract;
  assign active_o = active;
  assign active_level_o = st_reg.enf;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_deselect_stops: assert property (!sel |=> st_reg.fsm == IDLE && !fault_o ##1 !esr_o)
    else $error("monitoring kept after deselect");
  a_first_delay: assert property (st_reg.fsm == IDLE && sel |=> !active [*2])
    else $error("level enforced before delay");
  a_raise_now: assert property (active && sel && !(st_reg.pend && mif.tmr_done) &&
    req != st_reg.enf && lim_req >= lim_enf |=> st_reg.enf == $past(req))
    else $error("higher level not immediate");
  a_lower_waits: assert property (active && sel && !(st_reg.pend && mif.tmr_done) &&
    req != st_reg.enf && lim_req < lim_enf |=> st_reg.enf == $past(st_reg.enf)
    && st_reg.pend)
    else $error("lower level not delayed");
  a_pend_timed: assert property (st_reg.pend |-> mif.tmr_busy || mif.tmr_done)
    else $error("switchover pending without a running delay");
  a_overspeed: assert property (active && sel && !inval && speed_i > lim_enf |=>
    fault_o && fault_response_o == $past(st_reg.resp[st_reg.enf]))
    else $error("overspeed response wrong");
  a_bad_word: assert property (inval |=> alarm_o && fault_o &&
    fault_response_o == $past(st_reg.resp[0]))
    else $error("invalid word not answered");
  a_esr_gate: assert property (esr_o |-> $past(st_reg.resp[st_reg.enf]) >=
    lsm_pkg::ESR_RESP_MIN && $past(comm_fail_i) && $past(st_reg.bus_fail) != '0)
    else $error("stop-retract without qualification");
  a_delay_frozen: assert property (wr_i && addr_i == lsm_pkg::OFS_DELAY && sel |=>
    $stable(st_reg.delay))
    else $error("delay changed in operation");
  a_status_read: assert property (rd_i && addr_i == lsm_pkg::OFS_STATUS && active |=>
    rdata_o[lsm_pkg::ST_LVL_LSB +: 2] == $past(st_reg.enf) && rdata_o[0])
    else $error("status readback wrong");

  c_lower_switch: cover property (st_reg.pend ##1 !st_reg.pend && active);
  c_raise: cover property (active && req != st_reg.enf && lim_req >= lim_enf);
  c_overspeed: cover property (fault_o && !alarm_o);
  c_stop_retract: cover property (esr_o);

endmodule : limited_speed_monitor

// *** tb/ctrl_model.sv ***
`timescale 1ns/1ps
module ctrl_model #(
  parameter logic [15:0] STEP = 16'h0010
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // commands from the bench
  input wire logic [15:0] target_i,
  input wire logic lose_link_i,
  // drive side
  output logic [15:0] speed_o,
  output logic comm_fail_o
);
  // ---------------------------------------------------------------
  // setpoint ramp
  // ---------------------------------------------------------------
  // ramp, never a jump: the monitor must see a real deceleration
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      speed_o <= 16'h0000;
      comm_fail_o <= 1'b0;
    end else begin
      comm_fail_o <= lose_link_i;
      if (target_i > speed_o) begin
        speed_o <= (target_i - speed_o > STEP) ? speed_o + STEP : target_i;
      end else begin
        speed_o <= (speed_o - target_i > STEP) ? speed_o - STEP : target_i;
      end
    end
  end
endmodule : ctrl_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] target = 16'h0000;
  logic lose_link = 1'b0;
  logic [31:0] rdata_o;
  logic [15:0] speed_i;
  logic comm_fail_i;
  logic fault_o;
  logic [7:0] fault_response_o;
  logic alarm_o;
  logic esr_o;
  logic active_o;
  logic [1:0] active_level_o;
  logic [31:0] rv;
  int n_fail = 0;
  int comparisons = 0;

  always #5 core_clk_i = ~core_clk_i;

  limited_speed_monitor #(.TICK_CYCLES(4)) limited_speed_monitor_i (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .speed_i(speed_i),
    .comm_fail_i(comm_fail_i), .fault_o(fault_o), .fault_response_o(fault_response_o),
    .alarm_o(alarm_o), .esr_o(esr_o), .active_o(active_o), .active_level_o(active_level_o));
  ctrl_model ctrl_model_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .target_i(target),
    .lose_link_i(lose_link), .speed_o(speed_i), .comm_fail_o(comm_fail_i));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task cycles(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cycles
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    rv = rdata_o;
  endtask : rd
  task set_speed(input logic [15:0] v);
    int k;
    @(posedge core_clk_i);
    target <= v;
    for (k = 0; k < 64 && speed_i !== v; k++) cycles(1);
    if (speed_i !== v) begin
      n_fail++;
      results();
    end
    cycles(3);
  endtask : set_speed
  task wait_lvl(input logic act, input logic [1:0] lv);
    int k;
    for (k = 0; k < 100 && (active_o !== act || active_level_o !== lv); k++) cycles(1);
    if (active_o !== act || active_level_o !== lv) begin
      n_fail++;
      results();
    end
  endtask : wait_lvl

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_defaults;
    rd(lsm_pkg::OFS_DELAY);
    check(rv, lsm_pkg::DELAY_RST);
    rd(lsm_pkg::OFS_LIMIT_0 + 8'h0c);
    check(rv, {16'h0000, lsm_pkg::LIMIT_RST});
    rd(lsm_pkg::OFS_STATUS);
    check(rv, 32'h0000_0000);
    rd(8'hfc);
    check(rv, 32'h0000_0000);
    $display("test defaults done");
  endtask : t_defaults
  task t_level1;
    wr(lsm_pkg::OFS_LIMIT_0, 32'h0000_0064);
    wr(lsm_pkg::OFS_RESP_0, 32'h0000_0005);
    wr(lsm_pkg::OFS_DELAY, 32'h0000_0004);
    set_speed(16'h00c8);
    wr(lsm_pkg::OFS_CTRL, 32'h0000_0001);
    cycles(6);
    check(active_o, 1'h0);
    check(fault_o, 1'h0);
    wait_lvl(1'b1, 2'h0);
    cycles(2);
    check(fault_o, 1'h1);
    check(fault_response_o, 8'h05);
    check(active_level_o, 2'h0);
    rd(lsm_pkg::OFS_STATUS);
    check(rv & 32'h0000_01ff, 32'h0000_0021);
    set_speed(16'h0050);
    check(fault_o, 1'h0);
    $display("test level1 done");
  endtask : t_level1
  task t_switch;
    wr(lsm_pkg::OFS_LIMIT_0 + 8'h04, 32'h0000_0032);
    wr(lsm_pkg::OFS_LIMIT_0 + 8'h08, 32'h0000_012c);
    wr(lsm_pkg::OFS_RESP_0 + 8'h04, 32'h0000_0007);
    wr(lsm_pkg::OFS_CTRL, 32'h0000_0005);
    cycles(3);
    check(active_level_o, 2'h2);
    wr(lsm_pkg::OFS_CTRL, 32'h0000_0003);
    rd(lsm_pkg::OFS_STATUS);
    check(rv[lsm_pkg::ST_PEND_BIT], 1'h1);
    check(rv[4:3], 2'h1);
    set_speed(16'h0028);
    check(active_level_o, 2'h2);
    wait_lvl(1'b1, 2'h1);
    check(active_level_o, 2'h1);
    set_speed(16'h003c);
    check(fault_response_o, 8'h07);
    set_speed(16'h0028);
    $display("test switch done");
  endtask : t_switch
  task t_variable;
    wr(lsm_pkg::OFS_CTRL, 32'h0000_0000);
    cycles(3);
    check(active_o, 1'h0);
    check(fault_o, 1'h0);
    wr(lsm_pkg::OFS_CONFIG, 32'h0000_0001);
    wr(lsm_pkg::OFS_VAR_WORD, 32'h0000_4000);
    wr(lsm_pkg::OFS_CTRL, 32'h0000_0001);
    wait_lvl(1'b1, 2'h0);
    set_speed(16'h0033);
    check(fault_o, 1'h1);
    set_speed(16'h0032);
    check(fault_o, 1'h0);
    rd(lsm_pkg::OFS_SP_POS);
    check(rv, 32'h0000_0032);
    rd(lsm_pkg::OFS_SP_NEG);
    check(rv, 32'hffff_ffce);
    wr(lsm_pkg::OFS_WEIGHT, 32'h0000_0032);
    wr(lsm_pkg::OFS_GEAR_B, 32'h0000_0003);
    wr(lsm_pkg::OFS_GEAR_C, 32'h0000_0004);
    rd(lsm_pkg::OFS_SP_POS);
    check(rv, 32'h0000_0012);
    wr(lsm_pkg::OFS_GEAR_A, 32'h0000_0002);
    wr(lsm_pkg::OFS_CONFIG, 32'h0000_0003);
    rd(lsm_pkg::OFS_SP_POS);
    check(rv, 32'h0000_0025);
    set_speed(16'h0040);
    wr(lsm_pkg::OFS_CTRL, 32'h0000_0005);
    cycles(3);
    check(fault_o, 1'h0);
    wr(lsm_pkg::OFS_CTRL, 32'h0000_0000);
    wr(lsm_pkg::OFS_VAR_WORD, 32'h0000_0000);
    wr(lsm_pkg::OFS_CTRL, 32'h0000_0001);
    cycles(3);
    check(alarm_o, 1'h1);
    check(fault_response_o, 8'h05);
    wr(lsm_pkg::OFS_VAR_WORD, 32'h0000_7fff);
    cycles(3);
    check(alarm_o, 1'h0);
    $display("test variable done");
  endtask : t_variable
  task t_bus_loss;
    wait_lvl(1'b1, 2'h0);
    wr(lsm_pkg::OFS_BUS_FAIL, 32'h0000_0001);
    wr(lsm_pkg::OFS_RESP_0, 32'h0000_000a);
    @(posedge core_clk_i);
    lose_link <= 1'b1;
    cycles(4);
    check(esr_o, 1'h1);
    wr(lsm_pkg::OFS_RESP_0, 32'h0000_0009);
    cycles(3);
    check(esr_o, 1'h0);
    wr(lsm_pkg::OFS_RESP_0, 32'h0000_000a);
    wr(lsm_pkg::OFS_BUS_FAIL, 32'h0000_0000);
    cycles(3);
    check(esr_o, 1'h0);
    @(posedge core_clk_i);
    lose_link <= 1'b0;
    $display("test bus loss done");
  endtask : t_bus_loss
  task t_delay_lock;
    wr(lsm_pkg::OFS_DELAY, 32'h0000_0007);
    rd(lsm_pkg::OFS_DELAY);
    check(rv, 32'h0000_0004);
    wr(lsm_pkg::OFS_CTRL, 32'h0000_0000);
    wr(lsm_pkg::OFS_DELAY, 32'h0000_0007);
    rd(lsm_pkg::OFS_DELAY);
    check(rv, 32'h0000_0007);
    $display("test delay lock done");
  endtask : t_delay_lock

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // whole run is a few hundred cycles; this leaves a wide margin
  initial begin
    #200us;
    n_fail++;
    results();
  end

  initial begin
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    cycles(1);
    t_defaults();
    t_level1();
    t_switch();
    t_variable();
    t_bus_loss();
    t_delay_lock();
    results();
  end
endmodule : testbench
